/* File: dv/phy_event_interrupt_register_test.sv */
// Self-checking bench for the PHY event latch and enable register.
`timescale 1ns/100ps
`default_nettype none
module phy_event_interrupt_register_test;
    import phyev_pkg::*;
    typedef struct packed {
        logic [7:0] en;
        logic [7:0] ev;
        logic [15:0] rd;
        logic irq;
    } phyev_case_type;
    logic i_clk;
    logic i_reset;
    logic mdc;
    logic mdio_line;
    logic mdio_out;
    logic mdio_oe;
    logic irq;
    logic link_ok;
    logic saw;
    logic [7:0] evt;
    logic [15:0] status;
    logic [15:0] rd;
    int n_errors;
    int checked;
    phyev_case_type rows [0:10];
    phyev_event_reg dut (.i_clk(i_clk), .i_reset(i_reset), .i_mdc(mdc), .i_mdio_in(mdio_line),
        .o_mdio_out(mdio_out), .o_mdio_oe(mdio_oe), .i_long_transmit_evt(evt[PHYEV_BIT_LONG_TX]),
        .i_receive_fault_evt(evt[PHYEV_BIT_RX_FAULT]), .i_page_arrival_evt(evt[PHYEV_BIT_PAGE]),
        .i_parallel_detect_fault_evt(evt[PHYEV_BIT_PAR_FAULT]), .i_partner_ack_evt(evt[PHYEV_BIT_ACK]),
        .i_link_ok(link_ok), .i_far_fault_evt(evt[PHYEV_BIT_FAR_FAULT]),
        .i_negotiation_done_evt(evt[PHYEV_BIT_NEG_DONE]), .o_phy_irq(irq), .o_status_enable(status));
    phyev_mgmt_host host (.i_clk(i_clk), .i_mdio_out(mdio_out), .i_mdio_oe(mdio_oe), .o_mdc(mdc),
        .o_mdio(mdio_line));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    // Span is about three times what the frames need
    initial begin
        repeat (90000) @(posedge i_clk);
        n_errors++;
        conclude();
    end
    initial begin
        i_reset = 1'b1;
        evt = 8'h00;
        link_ok = 1'b1;
        rows = '{'{8'h80, 8'h80, 16'h8080, 1'b1}, '{8'h40, 8'h40, 16'h4040, 1'b1},
                 '{8'h20, 8'h20, 16'h2020, 1'b1}, '{8'h10, 8'h10, 16'h1010, 1'b1},
                 '{8'h08, 8'h08, 16'h0808, 1'b1}, '{8'h04, 8'h04, 16'h0404, 1'b1},
                 '{8'h02, 8'h02, 16'h0202, 1'b1}, '{8'h01, 8'h01, 16'h0101, 1'b1},
                 '{8'hbf, 8'h40, 16'hbf40, 1'b0}, '{8'hff, 8'hff, 16'hffff, 1'b1},
                 '{8'h00, 8'hff, 16'h00ff, 1'b0}};
        repeat (5) @(negedge i_clk);
        i_reset = 1'b0;
        host.frame(PHYEV_OP_READ, PHYEV_REG_ADDR, 16'h0000, rd, saw);
        check("reset read", PHYEV_RESET_VALUE, rd);
        check("answered", 16'h0001, {15'h0000, saw});
        $display("reset test done");
        // Low byte written as ones must not touch the flags
        for (int r = 0; r < 11; r++) begin
            host.frame(PHYEV_OP_WRITE, PHYEV_REG_ADDR, {rows[r].en, 8'hff}, rd, saw);
            @(negedge i_clk);
            evt = rows[r].ev & 8'hfb;
            link_ok = ~rows[r].ev[2];
            @(negedge i_clk);
            evt = 8'h00;
            link_ok = 1'b1;
            repeat (2) @(negedge i_clk);
            check("irq", {15'h0000, rows[r].irq}, {15'h0000, irq});
            check("live", rows[r].rd, status);
            host.frame(PHYEV_OP_READ, PHYEV_REG_ADDR, 16'h0000, rd, saw);
            check("read", rows[r].rd, rd);
            check("cleared", {rows[r].en, 8'h00}, status);
            $display("row %0d done", r);
        end
        host.frame(PHYEV_OP_READ, 5'h12, 16'h0000, rd, saw);
        check("other address", 16'h0000, {15'h0000, saw});
        link_ok = 1'b0;
        host.frame(PHYEV_OP_READ, PHYEV_REG_ADDR, 16'h0000, rd, saw);
        check("link drop", 16'h0004, rd);
        link_ok = 1'b1;
        host.frame(PHYEV_OP_READ, PHYEV_REG_ADDR, 16'h0000, rd, saw);
        check("link rise", 16'h0000, rd);
        $display("link test done");
        // An event held through the clearing read must survive it
        evt = 8'h01;
        host.frame(PHYEV_OP_READ, PHYEV_REG_ADDR, 16'h0000, rd, saw);
        check("held read", 16'h0001, rd);
        check("held kept", 16'h0001, status);
        evt = 8'h00;
        $display("held event test done");
        host.frame(PHYEV_OP_WRITE, PHYEV_REG_ADDR, 16'hff00, rd, saw);
        evt = 8'hff;
        @(negedge i_clk);
        evt = 8'h00;
        i_reset = 1'b1;
        @(negedge i_clk);
        i_reset = 1'b0;
        check("mid reset", PHYEV_RESET_VALUE, status);
        check("mid reset irq", 16'h0000, {15'h0000, irq});
        $display("mid-run reset test done");
        conclude();
    end
endmodule : phy_event_interrupt_register_test
`default_nettype wire

/* File: dv/phyev_mgmt_host.sv */
// Behavioural management host that frames reads and writes on the serial pins.
`timescale 1ns/100ps
`default_nettype none
module phyev_mgmt_host (
    input wire logic i_clk,
    input wire logic i_mdio_out,
    input wire logic i_mdio_oe,
    output logic o_mdc,
    output logic o_mdio
);
    import phyev_pkg::*;
    logic host_drv;
    logic host_bit;
    logic oe_seen;
    // Pull-up on the shared line: released means high
    assign o_mdio = i_mdio_oe ? i_mdio_out : (host_drv ? host_bit : 1'b1);
    initial begin
        o_mdc = 1'b0;
        host_drv = 1'b0;
        host_bit = 1'b1;
        oe_seen = 1'b0;
    end
    always @(posedge i_clk) begin
        if (i_mdio_oe) oe_seen = 1'b1;
    end
    // Data moves while the clock is low and is sampled on its rise; 160 ns a bit
    task automatic bit_cycle(input logic drv, input logic b, output logic seen);
        @(negedge i_clk);
        o_mdc = 1'b0;
        host_drv = drv;
        host_bit = b;
        repeat (8) @(negedge i_clk);
        o_mdc = 1'b1;
        seen = o_mdio;
        repeat (7) @(negedge i_clk);
    endtask : bit_cycle
    task automatic frame(input logic [1:0] op, input logic [4:0] reg_addr, input logic [15:0] wdata,
                         output logic [15:0] rdata, output logic saw_drive);
        logic [13:0] head;
        logic seen;
        logic wr;
        head = {2'h1, op, PHYEV_PHY_ADDR, reg_addr};
        wr = (op == PHYEV_OP_WRITE);
        oe_seen = 1'b0;
        for (int i = 0; i < 32; i++) bit_cycle(1'b1, 1'b1, seen);
        for (int i = 13; i >= 0; i--) bit_cycle(1'b1, head[i], seen);
        for (int i = 1; i >= 0; i--) bit_cycle(wr, i[0], seen);
        for (int i = 15; i >= 0; i--) begin
            bit_cycle(wr, wdata[i], seen);
            rdata[i] = seen;
        end
        // Clock stands low between frames
        @(negedge i_clk);
        o_mdc = 1'b0;
        host_drv = 1'b0;
        saw_drive = oe_seen;
    endtask : frame
endmodule : phyev_mgmt_host
`default_nettype wire

/* File: src/phyev_event_reg.sv */
// PHY event latch and enable register, reached over the serial management pins.
`timescale 1ns/100ps
`default_nettype none
module phyev_event_reg (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_mdc,
    input wire logic i_mdio_in,
    output logic o_mdio_out,
    output logic o_mdio_oe,
    input wire logic i_long_transmit_evt,
    input wire logic i_receive_fault_evt,
    input wire logic i_page_arrival_evt,
    input wire logic i_parallel_detect_fault_evt,
    input wire logic i_partner_ack_evt,
    input wire logic i_link_ok,
    input wire logic i_far_fault_evt,
    input wire logic i_negotiation_done_evt,
    output logic o_phy_irq,
    output logic [phyev_pkg::PHYEV_REG_W-1:0] o_status_enable
);
    import phyev_pkg::*;

    phyev_regs_type r_reg;
    phyev_regs_type r_next;
    logic mdc_rise;
    logic mdio_s;
    logic rd_take;
    logic wr_take;
    logic [7:0] ev;

    phyev_sync u_sync (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_mdc(i_mdc),
        .i_mdio_in(i_mdio_in),
        .o_mdc_rise(mdc_rise),
        .o_mdio(mdio_s)
    );

    always_comb begin
        r_next = r_reg;
        rd_take = 1'b0;
        wr_take = 1'b0;
        ev = '0;
        ev[PHYEV_BIT_LONG_TX] = i_long_transmit_evt;
        ev[PHYEV_BIT_RX_FAULT] = i_receive_fault_evt;
        ev[PHYEV_BIT_PAGE] = i_page_arrival_evt;
        ev[PHYEV_BIT_PAR_FAULT] = i_parallel_detect_fault_evt;
        ev[PHYEV_BIT_ACK] = i_partner_ack_evt;
        // Only the OK to FAIL edge counts; recovery is not an event
        ev[PHYEV_BIT_LINK_FAIL] = r_reg.link_prev & ~i_link_ok;
        ev[PHYEV_BIT_FAR_FAULT] = i_far_fault_evt;
        ev[PHYEV_BIT_NEG_DONE] = i_negotiation_done_evt;
        r_next.link_prev = i_link_ok;

        if (mdc_rise) begin
            r_next.shift = {r_reg.shift[14:0], mdio_s};
            r_next.bit_cnt = r_reg.bit_cnt - 5'h01;
            case (r_reg.st)
                PHYEV_IDLE: begin
                    if (mdio_s) begin
                        if (r_reg.pre_cnt != PHYEV_PREAMBLE_BITS) begin
                            r_next.pre_cnt = r_reg.pre_cnt + 6'h01;
                        end
                    end else begin
                        // A zero after a full preamble is the first start bit
                        if (r_reg.pre_cnt == PHYEV_PREAMBLE_BITS) begin
                            r_next.st = PHYEV_START;
                        end
                        r_next.pre_cnt = '0;
                    end
                end
                PHYEV_START: begin
                    r_next.st = mdio_s ? PHYEV_OPC : PHYEV_IDLE;
                    r_next.bit_cnt = PHYEV_OP_LAST;
                end
                PHYEV_OPC: begin
                    if (r_reg.bit_cnt == '0) begin
                        r_next.bit_cnt = PHYEV_ADDR_LAST;
                        r_next.is_read = (r_next.shift[1:0] == PHYEV_OP_READ);
                        if (r_next.shift[1:0] == PHYEV_OP_READ || r_next.shift[1:0] == PHYEV_OP_WRITE) begin
                            r_next.st = PHYEV_PHYAD;
                        end else begin
                            r_next.st = PHYEV_IDLE;
                        end
                    end
                end
                PHYEV_PHYAD: begin
                    if (r_reg.bit_cnt == '0) begin
                        r_next.mine = (r_next.shift[4:0] == PHYEV_PHY_ADDR);
                        r_next.st = PHYEV_REGAD;
                        r_next.bit_cnt = PHYEV_ADDR_LAST;
                    end
                end
                PHYEV_REGAD: begin
                    if (r_reg.bit_cnt == '0) begin
                        // Frames for other devices or registers still run to the end, silently
                        r_next.mine = r_reg.mine & (r_next.shift[4:0] == PHYEV_REG_ADDR);
                        r_next.st = PHYEV_TURN;
                        r_next.bit_cnt = PHYEV_TURN_LAST;
                    end
                end
                PHYEV_TURN: begin
                    if (r_reg.bit_cnt != '0) begin
                        // First turnaround bit stays released; drive zero for the second
                        if (r_reg.is_read && r_reg.mine) begin
                            r_next.mdio_oe = 1'b1;
                            r_next.mdio_out = 1'b0;
                        end
                    end else begin
                        r_next.st = PHYEV_DATA;
                        r_next.bit_cnt = PHYEV_DATA_LAST;
                        if (r_reg.is_read && r_reg.mine) begin
                            rd_take = 1'b1;
                            r_next.shift = {r_reg.enables, r_reg.flags};
                            r_next.mdio_out = r_reg.enables[7];
                        end
                    end
                end
                PHYEV_DATA: begin
                    if (r_reg.is_read && r_reg.mine) begin
                        r_next.mdio_out = r_reg.shift[14];
                        r_next.shift = {r_reg.shift[14:0], 1'b0};
                    end
                    if (r_reg.bit_cnt == '0) begin
                        r_next.st = PHYEV_IDLE;
                        r_next.pre_cnt = '0;
                        r_next.mdio_oe = 1'b0;
                        r_next.mdio_out = 1'b0;
                        // The lower byte is clear-on-read; written data there is dropped
                        wr_take = ~r_reg.is_read & r_reg.mine;
                    end
                end
                default: begin
                    r_next.st = PHYEV_IDLE;
                end
            endcase
        end

        // Clear first, then set, so a coincident event is kept
        if (rd_take) begin
            r_next.flags = '0;
        end
        r_next.flags = r_next.flags | ev;
        if (wr_take) begin
            r_next.enables = r_next.shift[15:8];
        end
        r_next.irq = |(r_next.flags & r_next.enables);

        if (i_reset) begin
            r_next = '0;
            r_next.flags = PHYEV_RESET_VALUE[7:0];
            r_next.enables = PHYEV_RESET_VALUE[15:8];
        end
    end

    always_ff @(posedge i_clk) begin
        r_reg <= r_next;
    end

    assign o_mdio_out = r_reg.mdio_out;
    assign o_mdio_oe = r_reg.mdio_oe;
    assign o_phy_irq = r_reg.irq;
    assign o_status_enable = {r_reg.enables, r_reg.flags};

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    reset_all_zero_a: assert property ($past(i_reset) |-> (o_status_enable == 16'h0000 && !o_phy_irq))
        else $error("register not zero after reset");
    jabber_set_a: assert property (i_long_transmit_evt |=> r_reg.flags[PHYEV_BIT_LONG_TX])
        else $error("jabber flag not set");
    rx_fault_set_a: assert property (i_receive_fault_evt |=> r_reg.flags[PHYEV_BIT_RX_FAULT])
        else $error("receive fault flag not set");
    events_latch_a: assert property (ev != 8'h00 |=> (r_reg.flags & $past(ev)) == $past(ev))
        else $error("event not latched into flag");
    link_fail_a: assert property ($fell(i_link_ok) |=> r_reg.flags[PHYEV_BIT_LINK_FAIL])
        else $error("link fail flag not set");
    link_recover_a: assert property ((!r_reg.flags[PHYEV_BIT_LINK_FAIL] && i_link_ok) |=> !r_reg.flags[PHYEV_BIT_LINK_FAIL])
        else $error("link flag set without failure");
    flag_sticky_a: assert property ((r_reg.flags[PHYEV_BIT_NEG_DONE] && !rd_take) |=> r_reg.flags[PHYEV_BIT_NEG_DONE])
        else $error("flag dropped without read");
    read_clear_a: assert property ((rd_take && ev == 8'h00) |=> r_reg.flags == 8'h00 && o_mdio_oe)
        else $error("read did not clear flags");
    read_msb_a: assert property (rd_take |=> o_mdio_out == $past(r_reg.enables[7]))
        else $error("first data bit wrong");
    turn_zero_a: assert property ($rose(o_mdio_oe) |-> !o_mdio_out ##1 o_mdio_oe [*8])
        else $error("turnaround not driven low");
    oe_owner_a: assert property (o_mdio_oe |-> (r_reg.is_read && r_reg.mine))
        else $error("pin driven outside own read");
    enable_write_a: assert property (wr_take |=> r_reg.enables == $past(r_next.shift[15:8]))
        else $error("enable write lost");
    irq_or_a: assert property (o_phy_irq == (|(r_reg.flags & r_reg.enables)))
        else $error("interrupt not OR of enabled flags");

    read_seen_c: cover property (rd_take);
    write_seen_c: cover property (wr_take);
    irq_rise_c: cover property ($rose(o_phy_irq));

endmodule : phyev_event_reg
`default_nettype wire

/* File: src/phyev_pkg.sv */
// Package for the PHY event latch: addresses, bit positions, reset values, state types.
package phyev_pkg;

    localparam int PHYEV_REG_W = 16;
    localparam int PHYEV_FLAG_W = 8;

    // Management addresses
    localparam logic [4:0] PHYEV_REG_ADDR = 5'h11;
    localparam logic [4:0] PHYEV_PHY_ADDR = 5'h00;

    // Value after reset of the whole register
    localparam logic [15:0] PHYEV_RESET_VALUE = 16'h0000;

    // Flag positions in the lower byte; enable n+8 gates flag n
    localparam int PHYEV_BIT_LONG_TX = 7;
    localparam int PHYEV_BIT_RX_FAULT = 6;
    localparam int PHYEV_BIT_PAGE = 5;
    localparam int PHYEV_BIT_PAR_FAULT = 4;
    localparam int PHYEV_BIT_ACK = 3;
    localparam int PHYEV_BIT_LINK_FAIL = 2;
    localparam int PHYEV_BIT_FAR_FAULT = 1;
    localparam int PHYEV_BIT_NEG_DONE = 0;
    localparam int PHYEV_EN_LSB = 8;

    // Frame field lengths: preamble as a full count of ones, the other fields as remaining-bit counts
    localparam logic [5:0] PHYEV_PREAMBLE_BITS = 6'h20;
    localparam logic [4:0] PHYEV_OP_LAST = 5'h01;
    localparam logic [4:0] PHYEV_ADDR_LAST = 5'h04;
    localparam logic [4:0] PHYEV_TURN_LAST = 5'h01;
    localparam logic [4:0] PHYEV_DATA_LAST = 5'h0f;

    // Opcodes
    localparam logic [1:0] PHYEV_OP_READ = 2'h2;
    localparam logic [1:0] PHYEV_OP_WRITE = 2'h1;

    typedef enum logic [2:0] {
        PHYEV_IDLE,
        PHYEV_START,
        PHYEV_OPC,
        PHYEV_PHYAD,
        PHYEV_REGAD,
        PHYEV_TURN,
        PHYEV_DATA
    } phyev_state_type;

    typedef struct packed {
        phyev_state_type st;
        logic [5:0] pre_cnt;
        logic [4:0] bit_cnt;
        logic [15:0] shift;
        logic is_read;
        logic mine;
        logic [7:0] flags;
        logic [7:0] enables;
        logic link_prev;
        logic mdio_out;
        logic mdio_oe;
        logic irq;
    } phyev_regs_type;

    typedef struct packed {
        logic mdc_meta;
        logic mdc_sync;
        logic mdc_prev;
        logic mdio_meta;
        logic mdio_sync;
    } phyev_sync_type;

endpackage : phyev_pkg

/* File: src/phyev_sync.sv */
// Two-flop synchronisers for the management clock and data pins, with clock rise detect.
`timescale 1ns/100ps
`default_nettype none
module phyev_sync (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_mdc,
    input wire logic i_mdio_in,
    output logic o_mdc_rise,
    output logic o_mdio
);
    import phyev_pkg::*;

    phyev_sync_type r_reg;
    phyev_sync_type r_next;

    always_comb begin
        r_next = r_reg;
        r_next.mdc_meta = i_mdc;
        r_next.mdc_sync = r_reg.mdc_meta;
        r_next.mdc_prev = r_reg.mdc_sync;
        r_next.mdio_meta = i_mdio_in;
        r_next.mdio_sync = r_reg.mdio_meta;
        if (i_reset) begin
            r_next = '0;
        end
    end

    always_ff @(posedge i_clk) begin
        r_reg <= r_next;
    end

    // Data and clock come from the second stages, the rise also from mdc_prev; data and clock share the same delay
    assign o_mdc_rise = r_reg.mdc_sync & ~r_reg.mdc_prev;
    assign o_mdio = r_reg.mdio_sync;

endmodule : phyev_sync
`default_nettype wire
